// ===== design/pbx_regs.svh
`ifndef PBX_REGS_SVH
`define PBX_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PBX_IDX_CH13 6'h2D
`define PBX_IDX_CH14 6'h2E
`define PBX_IDX_CH15 6'h2F
`define PBX_IDX_IRQ_SRC 6'h3F

// ----------------------------------------------------------------
// Channel register fields
// ----------------------------------------------------------------
`define PBX_BIT_EN 7
`define PBX_BIT_IEN 6
`define PBX_BIT_FB 1
`define PBX_BIT_SD 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PBX_RST_CTL 3'h0
`define PBX_RST_PIN 6'h3F
`define PBX_RST_SRC 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PBX_CLK_NS 5
`define PBX_FILT_NS 20
`define PBX_FILT_CYC ((`PBX_FILT_NS + `PBX_CLK_NS - 1) / `PBX_CLK_NS)
`define PBX_FB_LAT_NS 400
`define PBX_FB_LAT_CYC (`PBX_FB_LAT_NS / `PBX_CLK_NS)

`endif

// ===== design/pbx_pkg.sv
package pbx_pkg;

	typedef logic [7:0] pbx_addr_t;
	typedef logic [31:0] pbx_data_t;
	typedef logic [5:0] pbx_pins_t;
	typedef logic [2:0] pbx_chans_t;
	typedef logic [1:0] pbx_chan_t;

	typedef enum logic [0:0] {PBX_IDLE, PBX_ANSWER} pbx_apb_st_t;

endpackage : pbx_pkg

// ===== design/pbx_pin_if.sv
`timescale 1ns/1ps

interface pbx_pin_if;
	logic [5:0] pin_raw;
	logic [5:0] pin_filt;
	logic [5:0] pin_edge;

	modport filt
	(
		input pin_raw,
		output pin_filt,
		output pin_edge
	);

	modport core
	(
		output pin_raw,
		input pin_filt,
		input pin_edge
	);
endinterface : pbx_pin_if

// ===== design/pbx_pin_filter.sv
`timescale 1ns/1ps
`include "pbx_regs.svh"

module pbx_pin_filter
(
	// Clock and reset
	input logic pclk,
	input logic presetn,
	// Pin samples
	pbx_pin_if.filt pif
);
	import pbx_pkg::*;

	localparam logic [2:0] FILT_LAST = 3'(`PBX_FILT_CYC - 1);

	logic [5:0] sync_a_reg, sync_a_next;
	logic [5:0] sync_b_reg, sync_b_next;
	logic [5:0] filt_reg, filt_next;
	logic [5:0] edge_reg, edge_next;
	logic [2:0] cnt_reg [6];
	logic [2:0] cnt_next [6];

	// ----------------------------------------------------------------
	// Synchroniser and stability filter
	// ----------------------------------------------------------------
	always_comb
	begin
		sync_a_next = pif.pin_raw;
		sync_b_next = sync_a_reg;
		filt_next = filt_reg;
		for (int p = 0; p < 6; p++)
		begin
			cnt_next[p] = 3'h0;
			if (sync_b_reg[p] != filt_reg[p])
			begin
				// Glitches shorter than the filter window never reach the core
				if (cnt_reg[p] == FILT_LAST)
					filt_next[p] = sync_b_reg[p];
				else
					cnt_next[p] = cnt_reg[p] + 3'h1;
			end
		end
		edge_next = filt_next ^ filt_reg;
	end

	// Pins idle high through their pull-ups, so start at ones: no false edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_a_reg <= `PBX_RST_PIN;
			sync_b_reg <= `PBX_RST_PIN;
			filt_reg <= `PBX_RST_PIN;
			edge_reg <= 6'h00;
			for (int p = 0; p < 6; p++)
				cnt_reg[p] <= 3'h0;
		end
		else
		begin
			sync_a_reg <= sync_a_next;
			sync_b_reg <= sync_b_next;
			filt_reg <= filt_next;
			edge_reg <= edge_next;
			for (int p = 0; p < 6; p++)
				cnt_reg[p] <= cnt_next[p];
		end
	end

	assign pif.pin_filt = filt_reg;
	assign pif.pin_edge = edge_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_filt_stable;
		@(posedge pclk) disable iff (!presetn)
		$changed(filt_reg[0]) |-> $past(sync_b_reg[0], 1) == filt_reg[0]
			&& $past(sync_b_reg[0], 2) == filt_reg[0]
			&& $past(sync_b_reg[0], 3) == filt_reg[0]
			&& $past(sync_b_reg[0], 4) == filt_reg[0];
	endproperty
	a_filt_stable: assert property (p_filt_stable) else $error("filter passed a short pulse");

	property p_edge_marks_change;
		@(posedge pclk) disable iff (!presetn)
		$changed(filt_reg[0]) |-> edge_reg[0] ##1 !edge_reg[0] || $changed(filt_reg[0]);
	endproperty
	a_edge_marks_change: assert property (p_edge_marks_change) else $error("edge pulse missing");

endmodule : pbx_pin_filter

// ===== design/pbx_bypass_ctrl.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "pbx_regs.svh"

// How it works
// - Enable turns pin pair into FB out, SD in
// - Pin bypass-select still overrides enabled channel
// - Disabled channel leaves pins to general config
// - Enabled SD transition raises active-low interrupt
// - Interrupt source gets the channel register index
// - No interrupt while SD interrupt enable clear
// - Enabled FB pin is push-pull, follows bit
// - FB bit one keeps port in normal mode
// - FB bit zero forces port into bypass
// - Low filtered SD clears FB within 400 ns
// - Pins start as inputs with pull-up on
// - FB and SD bit reads return synchronised, filtered pin levels
// - SD bit read-only, mirrors the SD pin
// - SD one means signal present, zero absent
// - Channels 2Dh/2Eh/2Fh own P6.3-2/P6.5-4/P6.7-6
module pbx_bypass_ctrl
(
	// Clock and reset
	input logic pclk,
	input logic presetn,
	// APB slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input pbx_pkg::pbx_addr_t paddr,
	input pbx_pkg::pbx_data_t pwdata,
	output pbx_pkg::pbx_data_t prdata,
	output logic pready,
	output logic pslverr,
	// General pin configuration from the rest of the device
	input pbx_pkg::pbx_pins_t gp_out,
	input pbx_pkg::pbx_pins_t gp_oe,
	input pbx_pkg::pbx_pins_t byp_sel,
	input pbx_pkg::pbx_pins_t byp_data,
	// Pins P6.2 to P6.7, bit 0 is P6.2
	input pbx_pkg::pbx_pins_t pin_in,
	output pbx_pkg::pbx_pins_t pin_out,
	output pbx_pkg::pbx_pins_t pin_oe,
	output pbx_pkg::pbx_pins_t pin_pu,
	// Shared interrupt
	output logic int_n
);
	import pbx_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Channel 3 means no channel register at this address
	function automatic pbx_chan_t pbx_chan(input pbx_addr_t a);
		if (a[1:0] != 2'h0)
			return 2'h3;
		unique case (a[7:2])
			`PBX_IDX_CH13: return 2'h0;
			`PBX_IDX_CH14: return 2'h1;
			`PBX_IDX_CH15: return 2'h2;
			default: return 2'h3;
		endcase
	endfunction : pbx_chan

	function automatic logic [7:0] pbx_code(input pbx_chan_t c);
		return {2'h0, `PBX_IDX_CH13 + {4'h0, c}};
	endfunction : pbx_code

	logic [5:0] pin_filt;
	logic [5:0] pin_edge;
	pbx_pin_if pif ();

	assign pif.pin_raw = pin_in;
	assign pin_filt = pif.pin_filt;
	assign pin_edge = pif.pin_edge;

	pbx_pin_filter u_filter
	(
		.pclk(pclk),
		.presetn(presetn),
		.pif(pif)
	);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	pbx_apb_st_t st_reg, st_next;
	pbx_data_t prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	pbx_chan_t acc_ch;
	logic acc_src;
	logic commit_wr;
	logic [2:0] en_reg, en_next;
	logic [2:0] ien_reg, ien_next;
	logic [2:0] fb_reg, fb_next;
	logic [2:0] ev;
	logic pend_reg, pend_next;
	logic [7:0] src_reg, src_next;
	logic int_n_reg;
	logic irq_clr;

	always_comb
	begin
		acc_ch = pbx_chan(paddr);
		acc_src = paddr == {`PBX_IDX_IRQ_SRC, 2'h0};
		commit_wr = psel && penable && pready_reg && pwrite;
		st_next = st_reg;
		prdata_next = prdata_reg;
		pready_next = 1'h0;
		pslverr_next = 1'h0;
		unique case (st_reg)
			PBX_IDLE:
			begin
				if (psel && penable)
				begin
					// One wait state keeps pready a plain flop output
					st_next = PBX_ANSWER;
					pready_next = 1'h1;
					pslverr_next = acc_ch == 2'h3 && !acc_src;
					prdata_next = 32'h0;
					if (!pwrite && acc_ch != 2'h3)
					begin
						prdata_next[`PBX_BIT_EN] = en_reg[acc_ch];
						prdata_next[`PBX_BIT_IEN] = ien_reg[acc_ch];
						prdata_next[`PBX_BIT_FB] = pin_filt[{acc_ch, 1'h1}];
						prdata_next[`PBX_BIT_SD] = pin_filt[{acc_ch, 1'h0}];
					end
					else if (!pwrite && acc_src)
						prdata_next = {24'h0, src_reg};
				end
			end
			PBX_ANSWER:
				st_next = PBX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= PBX_IDLE;
			prdata_reg <= 32'h0;
			pready_reg <= 1'h0;
			pslverr_reg <= 1'h0;
		end
		else
		begin
			st_reg <= st_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// ----------------------------------------------------------------
	// Channel control bits and interrupt source
	// ----------------------------------------------------------------
	always_comb
	begin
		en_next = en_reg;
		ien_next = ien_reg;
		fb_next = fb_reg;
		for (int c = 0; c < 3; c++)
		begin
			if (commit_wr && acc_ch == 2'(c))
			begin
				// Reserved and SD bits of the write are dropped
				en_next[c] = pwdata[`PBX_BIT_EN];
				ien_next[c] = pwdata[`PBX_BIT_IEN];
				fb_next[c] = pwdata[`PBX_BIT_FB];
			end
			// Loss of signal beats a simultaneous software write
			if (en_reg[c] && !pin_filt[2 * c])
				fb_next[c] = 1'h0;
			ev[c] = en_reg[c] && ien_reg[c] && pin_edge[2 * c];
		end
		irq_clr = commit_wr && acc_src;
		pend_next = pend_reg;
		src_next = src_reg;
		if (irq_clr)
		begin
			pend_next = 1'h0;
			src_next = 8'h00;
		end
		// First event holds the source until cleared; a new one wins over the clear
		if (!pend_reg || irq_clr)
		begin
			for (int c = 2; c >= 0; c--)
			begin
				if (ev[c])
				begin
					pend_next = 1'h1;
					src_next = pbx_code(2'(c));
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_reg <= `PBX_RST_CTL;
			ien_reg <= `PBX_RST_CTL;
			fb_reg <= `PBX_RST_CTL;
			pend_reg <= 1'h0;
			src_reg <= `PBX_RST_SRC;
			int_n_reg <= 1'h1;
		end
		else
		begin
			en_reg <= en_next;
			ien_reg <= ien_next;
			fb_reg <= fb_next;
			pend_reg <= pend_next;
			src_reg <= src_next;
			int_n_reg <= !pend_next;
		end
	end

	// ----------------------------------------------------------------
	// Pin multiplexer
	// ----------------------------------------------------------------
	logic [5:0] pout_reg, pout_next;
	logic [5:0] poe_reg, poe_next;
	logic [5:0] ppu_reg, ppu_next;

	always_comb
	begin
		for (int p = 0; p < 6; p++)
		begin
			if (byp_sel[p])
			begin
				pout_next[p] = byp_data[p];
				poe_next[p] = 1'h1;
			end
			else if (en_reg[p / 2])
			begin
				// Odd pin of the pair is FB, push-pull; even pin is SD input
				pout_next[p] = (p % 2 == 1) ? fb_reg[p / 2] : 1'h0;
				poe_next[p] = p % 2 == 1;
			end
			else
			begin
				pout_next[p] = gp_out[p];
				poe_next[p] = gp_oe[p];
			end
		end
		ppu_next = ~poe_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pout_reg <= 6'h00;
			poe_reg <= 6'h00;
			ppu_reg <= 6'h3F;
		end
		else
		begin
			pout_reg <= pout_next;
			poe_reg <= poe_next;
			ppu_reg <= ppu_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign pin_out = pout_reg;
	assign pin_oe = poe_reg;
	assign pin_pu = ppu_reg;
	assign int_n = int_n_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	localparam int FB_LAT = `PBX_FB_LAT_CYC;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_rd13;
		psel && penable && !pready_reg && !pwrite && paddr == {`PBX_IDX_CH13, 2'h0};
	endsequence

	property p_enable_pins;
		en_reg[0] && !byp_sel[1] && !byp_sel[0] |=> poe_reg[1] && !poe_reg[0];
	endproperty
	a_enable_pins: assert property (p_enable_pins) else $error("pair not FB out, SD in");

	property p_bypass_kept;
		byp_sel[1] |=> poe_reg[1] && pout_reg[1] == $past(byp_data[1]);
	endproperty
	a_bypass_kept: assert property (p_bypass_kept) else $error("bypass select lost");

	property p_disabled_pins;
		!en_reg[0] && !byp_sel[1] |=> poe_reg[1] == $past(gp_oe[1])
			&& pout_reg[1] == $past(gp_out[1]);
	endproperty
	a_disabled_pins: assert property (p_disabled_pins) else $error("disabled channel drove pin");

	property p_irq_raise;
		!pend_reg && ev[0] |=> !int_n_reg && src_reg == pbx_code(2'h0);
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("irq or source missing");

	property p_no_irq;
		!pend_reg && ev == 3'h0 |=> int_n_reg;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("irq without enabled event");

	property p_fb_level;
		en_reg[0] && !byp_sel[1] |=> pout_reg[1] == $past(fb_reg[0]);
	endproperty
	a_fb_level: assert property (p_fb_level) else $error("FB pin wrong level");

	property p_fb_loss;
		en_reg[0] && !pin_filt[0] && !byp_sel[1] |-> ##[1:FB_LAT] !fb_reg[0] && !pout_reg[1];
	endproperty
	a_fb_loss: assert property (p_fb_loss) else $error("FB not cleared on loss");

	property p_pullup;
		ppu_reg == ~poe_reg;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up on a driven pin");

	property p_read_pins;
		s_rd13 |=> prdata_reg[1:0] == $past(pin_filt[1:0]) && pready_reg;
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("read not from pins");

	property p_reserved;
		s_rd13 |=> prdata_reg[5:2] == 4'h0 && prdata_reg[31:8] == 24'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	c_irq: cover property (!pend_reg ##1 pend_reg);
	c_loss: cover property (en_reg[0] && fb_reg[0] ##1 !fb_reg[0]);
	c_read: cover property (s_rd13 ##1 pready_reg);
	c_clear: cover property (pend_reg && irq_clr);

endmodule : pbx_bypass_ctrl

// ===== tb/pbx_link_model.sv
`timescale 1ns/1ps

module pbx_link_model
(
	// Device side pins
	input pbx_pkg::pbx_pins_t pin_out,
	input pbx_pkg::pbx_pins_t pin_oe,
	input pbx_pkg::pbx_pins_t pin_pu,
	output pbx_pkg::pbx_pins_t pin_in,
	// Far side state, one bit per channel
	input logic [2:0] sig_det_level,
	input logic [2:0] force_pull_down,
	output logic [2:0] bypassed
);
	import pbx_pkg::*;

	// ----------------------------------------------------------------
	// Pin resolution
	// ----------------------------------------------------------------
	// External pull-down outweighs the weak internal pull-up
	always_comb
	begin
		for (int c = 0; c < 3; c++)
		begin
			pin_in[2*c] = pin_oe[2*c] ? pin_out[2*c] : sig_det_level[c];
			if (pin_oe[2*c+1])
				pin_in[2*c+1] = pin_out[2*c+1];
			else
				pin_in[2*c+1] = ~force_pull_down[c] & pin_pu[2*c+1];
			bypassed[c] = ~pin_in[2*c+1];
		end
	end
endmodule : pbx_link_model

// ===== tb/port_bypass_ctrl_ch13_15_bench.sv
`timescale 1ns/1ps
`include "pbx_regs.svh"

module port_bypass_ctrl_ch13_15_bench;
	import pbx_pkg::*;

	localparam pbx_addr_t A13 = {`PBX_IDX_CH13, 2'h0};
	localparam pbx_addr_t A14 = {`PBX_IDX_CH14, 2'h0};
	localparam pbx_addr_t A15 = {`PBX_IDX_CH15, 2'h0};
	localparam pbx_addr_t AIRQ = {`PBX_IDX_IRQ_SRC, 2'h0};
	localparam int FB_MAX = `PBX_FB_LAT_CYC;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, int_n, rerr;
	pbx_addr_t paddr;
	pbx_data_t pwdata, prdata, rdat;
	pbx_pins_t gp_out, gp_oe, byp_sel, byp_data, pin_in, pin_out, pin_oe, pin_pu;
	logic [2:0] sig_det_level, force_pull_down, bypassed;
	int errors, n_tests;

	pbx_bypass_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gp_out(gp_out), .gp_oe(gp_oe), .byp_sel(byp_sel),
		.byp_data(byp_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pu(pin_pu), .int_n(int_n));

	pbx_link_model far_end (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
		.pin_in(pin_in), .sig_det_level(sig_det_level), .force_pull_down(force_pull_down),
		.bypassed(bypassed));

	always #2.5 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task report_and_stop;
		$display("mismatches %0d, checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	task chk(input pbx_data_t got, input pbx_data_t exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic wr, input pbx_addr_t a, input pbx_data_t d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 50)
		begin
			chk(32'h0, 32'h1);
			report_and_stop;
		end
	endtask : apb

	task rd(input pbx_addr_t a, input pbx_data_t exp, input logic err);
		apb(1'h0, a, 32'h0);
		chk(rdat, exp);
		chk({31'h0, rerr}, {31'h0, err});
	endtask : rd

	task cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc

	// Index 6 watches the interrupt line, others a pin output
	task wait_lvl(input int sel, input logic lvl, input int bound);
		int n;
		n = 0;
		while (((sel == 6) ? int_n : pin_out[sel]) !== lvl && n < bound)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk({31'h0, (sel == 6) ? int_n : pin_out[sel]}, {31'h0, lvl});
		if (n >= bound)
			report_and_stop;
	endtask : wait_lvl

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		pclk = 1'h0;
		presetn = 1'h0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		{gp_out, gp_oe, byp_sel, byp_data} = 24'h0;
		sig_det_level = 3'h7;
		force_pull_down = 3'h2;
		errors = 0;
		n_tests = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		cyc(1);
		chk({26'h0, pin_oe}, 32'h0);
		chk({26'h0, pin_pu}, 32'h3F);
		cyc(20);
		rd(A13, 32'h03, 1'h0);
		rd(A14, 32'h01, 1'h0);
		rd(A15, 32'h03, 1'h0);
		rd(AIRQ, 32'h0, 1'h0);
		apb(1'h1, A13, 32'h02);
		apb(1'h1, A13, 32'hC2);
		cyc(3);
		chk({26'h0, pin_oe}, 32'h02);
		chk({29'h0, bypassed}, 32'h2);
		rd(A13, 32'hC3, 1'h0);
		apb(1'h1, A13, 32'hC0);
		cyc(3);
		chk({29'h0, bypassed}, 32'h3);
		apb(1'h1, A13, 32'hFE);
		cyc(12);
		rd(A13, 32'hC3, 1'h0);
		apb(1'h1, A14, 32'h00);
		apb(1'h1, A14, 32'h81);
		cyc(3);
		chk({26'h0, pin_oe & pin_out}, 32'h02);
		chk({29'h0, bypassed}, 32'h2);
		@(posedge pclk);
		byp_sel <= 6'h02;
		cyc(3);
		chk({26'h0, pin_oe & ~pin_out}, 32'h0A);
		@(posedge pclk);
		byp_sel <= 6'h00;
		gp_oe <= 6'h30;
		gp_out <= 6'h20;
		apb(1'h1, A15, 32'h42);
		cyc(12);
		chk({26'h0, pin_oe}, 32'h3A);
		chk({26'h0, pin_out & 6'h30}, 32'h20);
		chk({31'h0, int_n}, 32'h1);
		@(posedge pclk);
		gp_oe <= 6'h00;
		gp_out <= 6'h00;
		cyc(12);
		apb(1'h1, A15, 32'h82);
		cyc(3);
		chk({31'h0, pin_out[5]}, 32'h1);
		@(posedge pclk);
		sig_det_level[2] <= 1'h0;
		wait_lvl(5, 1'h0, FB_MAX);
		cyc(20);
		chk({31'h0, int_n}, 32'h1);
		@(posedge pclk);
		sig_det_level[2] <= 1'h1;
		cyc(20);
		chk({31'h0, int_n}, 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'h1, pbx_addr_t'(A13 + 4 * i), 32'hC2);
			cyc(3);
			chk({31'h0, pin_out[2*i+1]}, 32'h1);
			@(posedge pclk);
			sig_det_level[i] <= 1'h0;
			wait_lvl(2 * i + 1, 1'h0, FB_MAX);
			wait_lvl(6, 1'h0, 20);
			rd(AIRQ, 32'h2D + i, 1'h0);
			rd(pbx_addr_t'(A13 + 4 * i), 32'hC0, 1'h0);
			apb(1'h1, AIRQ, 32'h0);
			cyc(2);
			chk({31'h0, int_n}, 32'h1);
			@(posedge pclk);
			sig_det_level[i] <= 1'h1;
			wait_lvl(6, 1'h0, 20);
			rd(AIRQ, 32'h2D + i, 1'h0);
			rd(pbx_addr_t'(A13 + 4 * i), 32'hC1, 1'h0);
			apb(1'h1, AIRQ, 32'h0);
			cyc(2);
		end
		rd(8'h40, 32'h0, 1'h1);
		rd(8'hB5, 32'h0, 1'h1);
		apb(1'h1, 8'h40, 32'hFF);
		chk({31'h0, rerr}, 32'h1);
		report_and_stop;
	end
endmodule : port_bypass_ctrl_ch13_15_bench
